// [design/tmc_pkg.sv]
// Operation
// R1: config bit 6 set means standby, no conversions
// R2: standby pin low also forces standby
// R3: value registers hold during standby
// R4: config bit 7 masks the alarm output
// R5: config bits 5-0 reserved, all reset zero
// R6: rate code divides converter period, 16 s-125 ms
// R7: host keeps rate upper five bits zero
// R8: rate register reads back last written value
// R9: high trips on greater, low on less
// R10: limits compare as signed values
// R11: one-shot write in software standby converts once
// R12: one-shot data byte ignored, not stored
// R13: two three-level pins pick nine addresses
// R14: address pins captured once after reset
// R15: start, 7-bit address msb first, then direction
// R16: address match acknowledged by low ninth clock
// R17: eight data clocks plus one acknowledge clock
// R18: master ends read with nack then stop
// R19: direction fixed per operation until new start
// R20: writes carry one or two bytes, reads one
// R21: first write byte loads pointer, second writes register
// R22: master sets pointer before reading when unsure
// R23: read returns register selected by pointer
// R24: separate read and write pointer codes
// R25: each conversion stores values and compares limits
// R26: undefined write codes acknowledged, change nothing
package tmc_pkg;
    localparam logic [7:0] PTR_LOCAL_RD = 8'h00;
    localparam logic [7:0] PTR_REMOTE_RD = 8'h01;
    localparam logic [7:0] PTR_STATUS_RD = 8'h02;
    localparam logic [7:0] PTR_CFG_RD = 8'h03;
    localparam logic [7:0] PTR_RATE_RD = 8'h04;
    localparam logic [7:0] PTR_LHI_RD = 8'h05;
    localparam logic [7:0] PTR_LLO_RD = 8'h06;
    localparam logic [7:0] PTR_RHI_RD = 8'h07;
    localparam logic [7:0] PTR_RLO_RD = 8'h08;
    localparam logic [7:0] PTR_CFG_WR = 8'h09;
    localparam logic [7:0] PTR_RATE_WR = 8'h0a;
    localparam logic [7:0] PTR_LHI_WR = 8'h0b;
    localparam logic [7:0] PTR_LLO_WR = 8'h0c;
    localparam logic [7:0] PTR_RHI_WR = 8'h0d;
    localparam logic [7:0] PTR_RLO_WR = 8'h0e;
    localparam logic [7:0] PTR_ONESHOT_WR = 8'h0f;
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [7:0] CFG_USED_MASK = 8'hc0;
    localparam logic [7:0] RATE_RST = 8'h02;
    localparam logic [7:0] HI_LIMIT_RST = 8'h7f;
    localparam logic [7:0] LO_LIMIT_RST = 8'hc9;
    localparam logic [7:0] VALUE_RST = 8'h80;
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_STANDBY_PIN_N_BIT = 6;
    localparam logic [2:0] RATE_FASTEST = 3'h7;
    localparam int STATUS_TRIP_LSB = 3;
    localparam int SYS_CLK_HZ = 100_000_000;
    localparam int CONV_MIN_PERIOD_MS = 125;
    localparam int CONV_MIN_PERIOD_CYC = SYS_CLK_HZ / 1000 * CONV_MIN_PERIOD_MS;
    localparam logic [1:0] PIN_LOW = 2'h0;
    localparam logic [1:0] PIN_HIGH = 2'h2;
    localparam logic [3:0] ADDR_TOP_LOW = 4'h3;
    localparam logic [3:0] ADDR_TOP_OPEN = 4'h5;
    localparam logic [3:0] ADDR_TOP_HIGH = 4'h9;
    localparam logic [2:0] ADDR_OFS_LOW = 3'h0;
    localparam logic [2:0] ADDR_OFS_OPEN = 3'h1;
    localparam logic [2:0] ADDR_OFS_HIGH = 3'h4;
    localparam logic [1:0] STRAP_SAMPLE = 2'h2;
    localparam logic [1:0] STRAP_DONE = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [1:0] WR_BYTES_MAX = 2'h2;

    typedef enum logic [2:0] {
        BUS_IDLE,
        BUS_ADDR,
        BUS_ADDR_ACK,
        BUS_WR_BYTE,
        BUS_WR_ACK,
        BUS_RD_BYTE,
        BUS_RD_ACK,
        BUS_WAIT_STOP
    } tmc_bus_e;
endpackage : tmc_pkg

// [design/tmc_smbus_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_smbus_ctrl #(
    parameter int CONV_BASE_CYC = tmc_pkg::CONV_MIN_PERIOD_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic serialClockLine,
    input wire logic serialDataLineIn,
    output logic serialDataLineOut,
    output logic serialDataLineOe_n,
    input wire logic standby_pin_n,
    input wire logic [1:0] addr_select_pin_a,
    input wire logic [1:0] addr_select_pin_b,
    input wire logic [7:0] localTempIn,
    input wire logic [7:0] remoteTempIn,
    output logic convStart,
    output logic standbyActive,
    output logic alarmLineOut,
    output logic alarmLineOe_n,
    output logic [6:0] deviceAddr
);
    // pin synchronisers, first stage read only by second
    logic [7:0] syncA_r, syncB_r;
    logic sclS, sdaS, stbyS;
    logic [1:0] pinAS, pinBS;
    assign {sclS, sdaS, stbyS, pinAS, pinBS} = syncB_r[7:1];

    tmc_pkg::tmc_bus_e state_r, state_nxt;
    logic sclPrev_r, sclPrev_nxt, sdaPrev_r, sdaPrev_nxt;
    logic [3:0] bitCnt_r, bitCnt_nxt;
    logic [7:0] rxShift_r, rxShift_nxt, txShift_r, txShift_nxt;
    logic [1:0] wrBytes_r, wrBytes_nxt;
    logic readDir_r, readDir_nxt, drive_r, drive_nxt;
    logic [7:0] ptr_r, ptr_nxt;
    logic [7:0] cfg_r, cfg_nxt, rate_r, rate_nxt;
    logic [7:0] lhi_r, lhi_nxt, llo_r, llo_nxt, rhi_r, rhi_nxt;
    logic [7:0] rlo_r, rlo_nxt;
    logic [7:0] localVal_r, localVal_nxt, remoteVal_r, remoteVal_nxt;
    logic [3:0] trip_r, trip_nxt;
    logic [31:0] divCnt_r, divCnt_nxt;
    logic [1:0] strapCnt_r, strapCnt_nxt;
    logic [6:0] devAddr_r, devAddr_nxt;
    logic conv_r, conv_nxt, alarm_r, alarm_nxt;

    logic sclRise, sclFall, startCond, stopCond;
    logic wrData, swStandby, running, convNow;
    logic [31:0] period;
    logic [7:0] rdData;
    logic [2:0] addrOfs;
    logic [3:0] addrTop;
    logic [2:0] pinBOfs;

    always_comb
    begin
        sclRise = sclS & ~sclPrev_r;
        sclFall = ~sclS & sclPrev_r;
        // start and stop only count while the clock stays high
        startCond = sclS & sclPrev_r & sdaPrev_r & ~sdaS; // [R15]
        stopCond = sclS & sclPrev_r & ~sdaPrev_r & sdaS;
        swStandby = cfg_r[tmc_pkg::CFG_STANDBY_PIN_N_BIT];
        running = ~swStandby & stbyS; // [R1] [R2]
        standbyActive = ~running;
        // slowest code shifts the base period up by seven
        period = 32'(CONV_BASE_CYC) << (tmc_pkg::RATE_FASTEST - rate_r[2:0]); // [R6]
        case (ptr_r) // [R23] [R24]
            tmc_pkg::PTR_LOCAL_RD: rdData = localVal_r;
            tmc_pkg::PTR_REMOTE_RD: rdData = remoteVal_r;
            tmc_pkg::PTR_STATUS_RD:
                rdData = 8'(trip_r) << tmc_pkg::STATUS_TRIP_LSB;
            tmc_pkg::PTR_CFG_RD: rdData = cfg_r;
            tmc_pkg::PTR_RATE_RD: rdData = rate_r; // [R8]
            tmc_pkg::PTR_LHI_RD: rdData = lhi_r;
            tmc_pkg::PTR_LLO_RD: rdData = llo_r;
            tmc_pkg::PTR_RHI_RD: rdData = rhi_r;
            tmc_pkg::PTR_RLO_RD: rdData = rlo_r;
            default: rdData = 8'h00;
        endcase
        case (pinAS) // [R13]
            tmc_pkg::PIN_LOW:
            begin
                addrTop = tmc_pkg::ADDR_TOP_LOW;
                addrOfs = tmc_pkg::ADDR_OFS_LOW;
            end
            tmc_pkg::PIN_HIGH:
            begin
                addrTop = tmc_pkg::ADDR_TOP_HIGH;
                addrOfs = tmc_pkg::ADDR_OFS_HIGH;
            end
            default:
            begin
                addrTop = tmc_pkg::ADDR_TOP_OPEN;
                addrOfs = tmc_pkg::ADDR_OFS_OPEN;
            end
        endcase
        // code 11 counts as an open pin, like 01
        case (pinBS) // [R13]
            tmc_pkg::PIN_LOW: pinBOfs = 3'h0;
            tmc_pkg::PIN_HIGH: pinBOfs = 3'h2;
            default: pinBOfs = 3'h1;
        endcase
    end

    always_comb
    begin
        state_nxt = state_r;
        sclPrev_nxt = sclS;
        sdaPrev_nxt = sdaS;
        bitCnt_nxt = bitCnt_r;
        rxShift_nxt = rxShift_r;
        txShift_nxt = txShift_r;
        wrBytes_nxt = wrBytes_r;
        readDir_nxt = readDir_r;
        drive_nxt = drive_r;
        ptr_nxt = ptr_r;
        wrData = 1'b0;
        case (state_r)
            tmc_pkg::BUS_ADDR, tmc_pkg::BUS_WR_BYTE:
            begin
                if (sclRise) // [R17]
                begin
                    rxShift_nxt = {rxShift_r[6:0], sdaS};
                    bitCnt_nxt = bitCnt_r + 4'h1;
                end
                else if (sclFall && bitCnt_r == tmc_pkg::BITS_PER_BYTE)
                begin
                    if (state_r == tmc_pkg::BUS_WR_BYTE)
                    begin
                        state_nxt = tmc_pkg::BUS_WR_ACK;
                        drive_nxt = 1'b1;
                        if (wrBytes_r == 2'h0)
                            ptr_nxt = rxShift_r; // [R21]
                        else if (wrBytes_r == 2'h1)
                            wrData = 1'b1; // [R20] [R21]
                        if (wrBytes_r != tmc_pkg::WR_BYTES_MAX)
                            wrBytes_nxt = wrBytes_r + 2'h1;
                    end
                    else if (rxShift_r[7:1] == devAddr_r)
                    begin
                        state_nxt = tmc_pkg::BUS_ADDR_ACK; // [R16]
                        drive_nxt = 1'b1;
                        readDir_nxt = rxShift_r[0]; // [R15] [R19]
                        wrBytes_nxt = 2'h0;
                    end
                    else
                        state_nxt = tmc_pkg::BUS_WAIT_STOP; // [R16]
                end
            end
            tmc_pkg::BUS_ADDR_ACK:
                if (sclFall)
                begin
                    bitCnt_nxt = 4'h0;
                    if (readDir_r)
                    begin
                        state_nxt = tmc_pkg::BUS_RD_BYTE;
                        txShift_nxt = rdData;
                        drive_nxt = ~rdData[7];
                    end
                    else
                    begin
                        state_nxt = tmc_pkg::BUS_WR_BYTE;
                        drive_nxt = 1'b0;
                    end
                end
            tmc_pkg::BUS_WR_ACK:
                if (sclFall)
                begin
                    state_nxt = tmc_pkg::BUS_WR_BYTE;
                    drive_nxt = 1'b0;
                    bitCnt_nxt = 4'h0;
                end
            tmc_pkg::BUS_RD_BYTE:
                if (sclRise)
                    bitCnt_nxt = bitCnt_r + 4'h1;
                else if (sclFall)
                begin
                    if (bitCnt_r == tmc_pkg::BITS_PER_BYTE)
                    begin
                        state_nxt = tmc_pkg::BUS_RD_ACK;
                        drive_nxt = 1'b0;
                    end
                    else
                    begin
                        txShift_nxt = {txShift_r[6:0], 1'b0};
                        drive_nxt = ~txShift_r[6];
                    end
                end
            tmc_pkg::BUS_RD_ACK:
                if (sclRise)
                    // nack ends the read; an ack repeats the same register
                    state_nxt = sdaS ? tmc_pkg::BUS_WAIT_STOP
                                     : tmc_pkg::BUS_ADDR_ACK; // [R18]
            tmc_pkg::BUS_IDLE, tmc_pkg::BUS_WAIT_STOP: ;
            default: state_nxt = tmc_pkg::BUS_IDLE;
        endcase
        if (startCond) // [R19]
        begin
            state_nxt = tmc_pkg::BUS_ADDR;
            bitCnt_nxt = 4'h0;
            drive_nxt = 1'b0;
        end
        else if (stopCond)
        begin
            state_nxt = tmc_pkg::BUS_IDLE;
            drive_nxt = 1'b0;
        end
    end

    always_comb
    begin
        cfg_nxt = cfg_r;
        rate_nxt = rate_r;
        lhi_nxt = lhi_r;
        llo_nxt = llo_r;
        rhi_nxt = rhi_r;
        rlo_nxt = rlo_r;
        conv_nxt = 1'b0;
        if (wrData)
            case (ptr_r) // [R24] [R26]
                tmc_pkg::PTR_CFG_WR: cfg_nxt = rxShift_r & tmc_pkg::CFG_USED_MASK; // [R5]
                tmc_pkg::PTR_RATE_WR: rate_nxt = rxShift_r; // [R7] [R8]
                tmc_pkg::PTR_LHI_WR: lhi_nxt = rxShift_r; // [R10]
                tmc_pkg::PTR_LLO_WR: llo_nxt = rxShift_r;
                tmc_pkg::PTR_RHI_WR: rhi_nxt = rxShift_r;
                tmc_pkg::PTR_RLO_WR: rlo_nxt = rxShift_r;
                // data byte dropped, the write alone triggers
                tmc_pkg::PTR_ONESHOT_WR: conv_nxt = swStandby & stbyS; // [R11] [R12]
                default: ;
            endcase
        divCnt_nxt = 32'h0;
        if (running && divCnt_r < period - 32'h1)
            divCnt_nxt = divCnt_r + 32'h1;
        // a standby write in this cycle cancels the pending pulse
        else if (running && !cfg_nxt[tmc_pkg::CFG_STANDBY_PIN_N_BIT])
            conv_nxt = 1'b1; // [R6] [R1]
        convNow = conv_r;
        convStart = conv_r;
        localVal_nxt = localVal_r; // [R3]
        remoteVal_nxt = remoteVal_r;
        trip_nxt = trip_r;
        if (convNow) // [R25]
        begin
            localVal_nxt = localTempIn;
            remoteVal_nxt = remoteTempIn;
            trip_nxt[3] = $signed(localTempIn) > $signed(lhi_r); // [R9] [R10]
            trip_nxt[2] = $signed(localTempIn) < $signed(llo_r);
            trip_nxt[1] = $signed(remoteTempIn) > $signed(rhi_r);
            trip_nxt[0] = $signed(remoteTempIn) < $signed(rlo_r);
        end
        // masking also drops an alarm already showing
        alarm_nxt = (|trip_nxt) & ~cfg_nxt[tmc_pkg::CFG_MASK_BIT]; // [R4]
        // straps are sampled once the synchronisers hold real levels
        strapCnt_nxt = strapCnt_r;
        devAddr_nxt = devAddr_r;
        if (strapCnt_r != tmc_pkg::STRAP_DONE)
            strapCnt_nxt = strapCnt_r + 2'h1;
        if (strapCnt_r == tmc_pkg::STRAP_SAMPLE) // [R14]
            devAddr_nxt = {addrTop, 3'(addrOfs + pinBOfs)}; // [R13]
    end

    assign serialDataLineOut = 1'b0;
    assign serialDataLineOe_n = ~drive_r; // [R16]
    assign alarmLineOut = 1'b0;
    assign deviceAddr = devAddr_r;

    assign alarmLineOe_n = ~alarm_r;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            syncA_r <= 8'hff;
            syncB_r <= 8'hff;
            state_r <= tmc_pkg::BUS_IDLE;
            sclPrev_r <= 1'b1;
            sdaPrev_r <= 1'b1;
            bitCnt_r <= 4'h0;
            rxShift_r <= 8'h00;
            txShift_r <= 8'h00;
            wrBytes_r <= 2'h0;
            readDir_r <= 1'b0;
            drive_r <= 1'b0;
            ptr_r <= 8'h00;
            cfg_r <= tmc_pkg::CFG_RST; // [R5]
            rate_r <= tmc_pkg::RATE_RST;
            lhi_r <= tmc_pkg::HI_LIMIT_RST;
            llo_r <= tmc_pkg::LO_LIMIT_RST;
            rhi_r <= tmc_pkg::HI_LIMIT_RST;
            rlo_r <= tmc_pkg::LO_LIMIT_RST;
            localVal_r <= tmc_pkg::VALUE_RST;
            remoteVal_r <= tmc_pkg::VALUE_RST;
            trip_r <= 4'h0;
            divCnt_r <= 32'h0;
            strapCnt_r <= 2'h0;
            devAddr_r <= 7'h00;
            conv_r <= 1'b0;
            alarm_r <= 1'b0;
        end
        else
        begin
            syncA_r <= {serialClockLine, serialDataLineIn, standby_pin_n,
                        addr_select_pin_a, addr_select_pin_b, 1'b0};
            syncB_r <= syncA_r;
            state_r <= state_nxt;
            sclPrev_r <= sclPrev_nxt;
            sdaPrev_r <= sdaPrev_nxt;
            bitCnt_r <= bitCnt_nxt;
            rxShift_r <= rxShift_nxt;
            txShift_r <= txShift_nxt;
            wrBytes_r <= wrBytes_nxt;
            readDir_r <= readDir_nxt;
            drive_r <= drive_nxt;
            ptr_r <= ptr_nxt;
            cfg_r <= cfg_nxt;
            rate_r <= rate_nxt;
            lhi_r <= lhi_nxt;
            llo_r <= llo_nxt;
            rhi_r <= rhi_nxt;
            rlo_r <= rlo_nxt;
            localVal_r <= localVal_nxt;
            remoteVal_r <= remoteVal_nxt;
            trip_r <= trip_nxt;
            divCnt_r <= divCnt_nxt;
            strapCnt_r <= strapCnt_nxt;
            devAddr_r <= devAddr_nxt;
            conv_r <= conv_nxt;
            alarm_r <= alarm_nxt;
        end
    end
endmodule : tmc_smbus_ctrl
`default_nettype wire

// [tb/tmc_smbus_ctrl_props.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_smbus_ctrl_props #(
    parameter int CONV_BASE_CYC = 20
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic serialClockLine,
    input wire logic serialDataLineOe_n,
    input wire logic standby_pin_n,
    input wire logic [1:0] addr_select_pin_a,
    input wire logic [1:0] addr_select_pin_b,
    input wire logic convStart,
    input wire logic standbyActive,
    input wire logic alarmLineOe_n,
    input wire logic [6:0] deviceAddr
);
    logic [2:0] relCnt_r;
    logic [2:0] relCnt_nxt;

    function automatic logic [6:0] addr_of(input logic [1:0] a,
                                           input logic [1:0] b);
        logic [6:0] base;
        base = (a == 2'h0) ? 7'h18 : (a == 2'h2) ? 7'h4c : 7'h29;
        return base + ((b == 2'h0) ? 7'h00 : (b == 2'h2) ? 7'h02 : 7'h01);
    endfunction : addr_of

    // saturating count of clocks since reset release
    always_comb
    begin
        relCnt_nxt = (relCnt_r == 3'h7) ? relCnt_r : relCnt_r + 3'h1;
    end
    always_ff @(posedge sys_clk)
    begin
        relCnt_r <= rst_n ? relCnt_nxt : 3'h0;
    end

    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    pin_standby_a: assert property (!standby_pin_n [*3] |-> standbyActive)
        else $error("standby pin low but no standby");
    pin_noconv_a: assert property (!standby_pin_n [*4] |-> !convStart)
        else $error("conversion while pin standby");
    conv_pulse_a: assert property (convStart |=> !convStart [*8])
        else $error("conversion pulse too long or too close");
    addr_strap_a: assert property (relCnt_r == 3'h6 |->
        deviceAddr == addr_of(addr_select_pin_a, addr_select_pin_b))
        else $error("slave address does not match straps");
    addr_hold_a: assert property (relCnt_r == 3'h7 |-> $stable(deviceAddr))
        else $error("slave address changed after capture");
    data_settle_a: assert property (serialClockLine [*2] |->
        $stable(serialDataLineOe_n))
        else $error("data drive changed while clock high");
    ack_hold_a: assert property ($fell(serialDataLineOe_n) |=>
        !serialDataLineOe_n [*5])
        else $error("data drive too short");
    line_release_a: assert property (!serialDataLineOe_n |->
        ##[1:120] serialDataLineOe_n)
        else $error("data line never released");

    conv_seen_c: cover property (convStart);
    ack_seen_c: cover property ($fell(serialDataLineOe_n));
    alarm_seen_c: cover property (!alarmLineOe_n);
endmodule : tmc_smbus_ctrl_props

bind tmc_smbus_ctrl tmc_smbus_ctrl_props #(.CONV_BASE_CYC(CONV_BASE_CYC))
    tmc_smbus_ctrl_props_i (.sys_clk, .rst_n, .serialClockLine,
    .serialDataLineOe_n, .standby_pin_n, .addr_select_pin_a,
    .addr_select_pin_b, .convStart, .standbyActive, .alarmLineOe_n,
    .deviceAddr);
`default_nettype wire

// [tb/tmc_smbus_host.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_smbus_host (
    output var logic scl,
    output var logic sdaLow,
    input wire logic sda
);
    // clock stands high between frames
    initial
    begin
        scl = 1'b1;
        sdaLow = 1'b0;
    end
    task bit_out(input logic b); // data moves only while clock low
        sdaLow = !b;
        #20 scl = 1'b1;
        #40 scl = 1'b0;
        #20;
    endtask : bit_out
    task bit_in(output logic b);
        sdaLow = 1'b0;
        #20 scl = 1'b1;
        #30 b = sda;
        #10 scl = 1'b0;
        #20;
    endtask : bit_in
    task start();
        sdaLow = 1'b0;
        #20 scl = 1'b1;
        #40 sdaLow = 1'b1;
        #40 scl = 1'b0;
        #20;
    endtask : start
    task stop();
        sdaLow = 1'b1;
        #20 scl = 1'b1;
        #40 sdaLow = 1'b0;
        #100;
    endtask : stop
    task byte_out(input logic [7:0] d, output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--)
            bit_out(d[i]);
        bit_in(a);
        ack = !a;
    endtask : byte_out
    // pointer byte, then at most one data byte
    task wr(input logic [6:0] adr, input logic [7:0] p, input logic two,
            input logic [7:0] d, output logic ack);
        logic k;
        start();
        byte_out({adr, 1'b0}, ack);
        if (ack)
            byte_out(p, k);
        if (ack && two)
            byte_out(d, k);
        stop();
    endtask : wr
    // one byte, then no-acknowledge and stop
    task rd(input logic [6:0] adr, output logic [7:0] d, output logic ack);
        start();
        byte_out({adr, 1'b1}, ack);
        for (int i = 7; i >= 0; i--)
            bit_in(d[i]);
        bit_out(1'b1);
        stop();
    endtask : rd
endmodule : tmc_smbus_host
`default_nettype wire

// [tb/tmc_smbus_ctrl_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module tmc_smbus_ctrl_tb;
    localparam logic [6:0] MY_ADDR = 7'h2b;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic serialClockLine, hostLow, sda, serialDataLineOe_n, ack;
    logic standby_pin_n = 1'b1;
    logic [1:0] addr_select_pin_a = 2'h1;
    logic [1:0] addr_select_pin_b = 2'h2;
    logic [7:0] localTempIn = 8'h00;
    logic [7:0] remoteTempIn = 8'h00;
    logic convStart, standbyActive, alarmLineOe_n;
    logic [6:0] deviceAddr;
    logic [7:0] got;
    logic [7:0] rstVal [4] = '{8'h7f, 8'hc9, 8'h7f, 8'hc9};
    int num_errors = 0;
    int checked = 0;
    int convCnt = 0;
    int n;

    always #5 sys_clk = !sys_clk;
    // pull-up: low if either side pulls
    assign sda = !hostLow && serialDataLineOe_n;
    always @(posedge sys_clk) if (convStart) convCnt++;

    tmc_smbus_ctrl #(.CONV_BASE_CYC(20)) tmc_smbus_ctrl_i (.sys_clk, .rst_n,
        .serialClockLine, .serialDataLineIn(sda), .serialDataLineOut(),
        .serialDataLineOe_n, .standby_pin_n, .addr_select_pin_a,
        .addr_select_pin_b, .localTempIn, .remoteTempIn, .convStart,
        .standbyActive, .alarmLineOut(), .alarmLineOe_n, .deviceAddr);
    tmc_smbus_host tmc_smbus_host_i (.scl(serialClockLine), .sdaLow(hostLow),
        .sda(sda));

    task automatic cmp(input string what, input logic [7:0] exp,
                       input logic [7:0] seen);
        checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : cmp
    task automatic wr(input logic [7:0] p, input logic two,
                      input logic [7:0] d);
        // bus edges kept one step past the sampling clock edge
        @(posedge sys_clk);
        #1;
        tmc_smbus_host_i.wr(MY_ADDR, p, two, d, ack);
        cmp("write ack", 8'h01, {7'h00, ack});
    endtask : wr
    task automatic rdp(input logic [7:0] exp);
        @(posedge sys_clk);
        #1;
        tmc_smbus_host_i.rd(MY_ADDR, got, ack);
        cmp("read ack", 8'h01, {7'h00, ack});
        cmp("read data", exp, got);
    endtask : rdp
    // pointer is set first, its value is never assumed
    task automatic rd(input logic [7:0] p, input logic [7:0] exp);
        wr(p, 1'b0, 8'h00);
        rdp(exp);
    endtask : rd
    task automatic drive(input logic [7:0] l, input logic [7:0] r);
        @(posedge sys_clk);
        #1;
        localTempIn = l;
        remoteTempIn = r;
    endtask : drive
    task automatic results();
        $display("checks %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : results

    initial
    begin
        #1000000;
        num_errors++;
        results();
    end

    initial
    begin
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (10) @(posedge sys_clk);
        rd(8'h03, 8'h00);
        rd(8'h04, 8'h02);
        for (int i = 0; i < 4; i++)
            rd(8'h05 + i[7:0], rstVal[i]);
        rd(8'h09, 8'h00);
        $display("test reset values done");
        wr(8'h0a, 1'b1, 8'h07);
        rd(8'h04, 8'h07);
        wr(8'h09, 1'b1, 8'hff);
        rd(8'h03, 8'hc0);
        wr(8'h09, 1'b1, 8'h00);
        $display("test register access done");
        drive(8'h33, 8'h05);
        wr(8'h0b, 1'b1, 8'h32);
        wr(8'h0c, 1'b1, 8'h40);
        wr(8'h0d, 1'b1, 8'h05);
        wr(8'h0e, 1'b1, 8'hf6);
        rd(8'h02, 8'h60);
        rd(8'h00, 8'h33);
        rd(8'h01, 8'h05);
        cmp("alarm drive", 8'h00, {7'h00, alarmLineOe_n});
        wr(8'h09, 1'b1, 8'h80);
        cmp("alarm drive", 8'h01, {7'h00, alarmLineOe_n});
        $display("test limits done");
        wr(8'h09, 1'b1, 8'h40);
        n = convCnt;
        drive(8'h11, 8'h05);
        rd(8'h00, 8'h33);
        cmp("conversions", 8'(n), 8'(convCnt));
        wr(8'h0f, 1'b1, 8'ha5);
        cmp("conversions", 8'(n + 1), 8'(convCnt));
        rd(8'h00, 8'h11);
        rd(8'h03, 8'h40);
        rd(8'h04, 8'h07);
        $display("test software standby done");
        drive(8'h22, 8'h05);
        wr(8'h09, 1'b1, 8'h00);
        @(posedge sys_clk);
        #1 standby_pin_n = 1'b0;
        repeat (4) @(posedge sys_clk);
        n = convCnt;
        drive(8'h44, 8'h05);
        rd(8'h00, 8'h22);
        cmp("conversions", 8'(n), 8'(convCnt));
        cmp("standby", 8'h01, {7'h00, standbyActive});
        @(posedge sys_clk);
        #1 standby_pin_n = 1'b1;
        $display("test pin standby done");
        tmc_smbus_host_i.wr(7'h2a, 8'h03, 1'b0, 8'h00, ack);
        cmp("stray ack", 8'h00, {7'h00, ack});
        @(posedge sys_clk);
        #1 addr_select_pin_a = 2'h0;
        cmp("address", 8'h2b, {1'b0, deviceAddr});
        wr(8'h20, 1'b1, 8'hff);
        rd(8'h04, 8'h07);
        rdp(8'h07);
        rd(8'h03, 8'h00);
        $display("test address done");
        results();
    end
endmodule : tmc_smbus_ctrl_tb
`default_nettype wire
